// ### core/temp_sensor_config_alert.sv
// Configuration register, conversion sequencing and alarm channels
`timescale 1ns/1ns
module temp_sensor_config_alert #(
  parameter int unsigned PROG_WAIT = sensor_cfg_pkg::PROG_CYCLES,
  parameter int unsigned RATE_UNIT = sensor_cfg_pkg::RATE_UNIT_CYCLES
) (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic CONV_DONE_I,
  input wire logic signed [13:0] TEMP_RESULT_I,
  input wire logic signed [13:0] HIGH_LIMIT1_I,
  input wire logic signed [13:0] LOW_LIMIT1_I,
  input wire logic signed [13:0] HIGH_LIMIT2_I,
  input wire logic signed [13:0] LOW_LIMIT2_I,
  output logic CONV_START_O,
  output logic CONV_ABORT_O,
  output logic SHUTDOWN_O,
  output logic NV_PROG_O,
  output logic [15:0] NV_DATA_O,
  output logic ALARM_OUTPUT_1_O,
  output logic ALARM_OUTPUT_2_O
);
  import sensor_cfg_pkg::*;

  typedef struct packed {
    conv_state_t st;
    logic [2:0] rate;
    logic shut_sel;
    logic sty1;
    logic polar1;
    logic sty2;
    logic polar2;
    logic unlock;
    logic single;
    logic [31:0] busy_cnt;
    logic [31:0] per_cnt;
    logic [13:0] temp;
    logic [15:0] rdata;
    logic start;
    logic abort;
    logic prog;
    logic [15:0] nv_data;
  } main_t;

  localparam main_t MAIN_RESET = '{
    st: ST_CONV, rate: CFG_RESET[15:13], shut_sel: CFG_RESET[BIT_SHUT],
    sty1: CFG_RESET[BIT_STY1], polar1: CFG_RESET[BIT_POLAR1],
    sty2: CFG_RESET[BIT_STY2], polar2: CFG_RESET[BIT_POLAR2],
    unlock: UNLOCK_RESET, single: 1'b0, busy_cnt: 32'h0, per_cnt: 32'h0,
    temp: 14'h0, rdata: 16'h0, start: 1'b0, abort: 1'b0, prog: 1'b0,
    nv_data: 16'h0};

  main_t q;
  main_t d;
  logic done;
  logic cfg_rd;
  logic cfg_wr;
  logic tmp_wr;
  logic [2:0] new_rate;
  logic new_shut;
  logic [1:0] upper;
  logic [1:0] lower;
  logic [1:0] alarm;
  logic signed [13:0] hi_lim [2];
  logic signed [13:0] lo_lim [2];
  logic [1:0] sty;
  logic [1:0] pol;

  // Continuous update period; lower rate codes give longer periods
  function automatic logic [31:0] period_of(input logic [2:0] r);
    period_of = RATE_UNIT << (3'd7 - r);
  endfunction

  // ***************************************************************
  // Sequencing and register access
  // ***************************************************************
  assign done = CONV_DONE_I && (q.st == ST_CONV);
  assign cfg_rd = REG_RD_I && (REG_ADDR_I == CFG_ADDR);
  // Writes are refused while nonvolatile programming runs
  assign cfg_wr = REG_WR_I && (REG_ADDR_I == CFG_ADDR) && (q.busy_cnt == 0);
  assign tmp_wr = REG_WR_I && (REG_ADDR_I == TEMP_ADDR) && (q.busy_cnt == 0);

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.abort = 1'b0;
    d.prog = 1'b0;
    new_rate = q.rate;
    new_shut = q.shut_sel;
    if (q.busy_cnt != 0) begin
      d.busy_cnt = q.busy_cnt - 32'd1;
    end
    case (q.st)
      ST_SHUT: begin
        d.per_cnt = 32'h0;
      end
      ST_CONV: begin
        if (q.per_cnt != 0) begin
          d.per_cnt = q.per_cnt - 32'd1;
        end
        if (CONV_DONE_I) begin
          d.temp = TEMP_RESULT_I;
          if (q.single || q.shut_sel) begin
            d.st = ST_SHUT;
            d.single = 1'b0;
          end else begin
            d.st = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (q.per_cnt == 0) begin
          d.st = ST_CONV;
          d.start = 1'b1;
          d.per_cnt = period_of(q.rate);
        end else begin
          d.per_cnt = q.per_cnt - 32'd1;
        end
      end
      default: begin
        d.st = ST_SHUT;
      end
    endcase
    if (tmp_wr) begin
      d.unlock = REG_WDATA_I[BIT_UNLOCK];
    end
    if (cfg_wr) begin
      if (q.unlock) begin
        // Program the stored copy only; live bits stay as they are
        d.prog = 1'b1;
        d.nv_data = REG_WDATA_I & CFG_WR_MASK;
        d.busy_cnt = PROG_WAIT;
      end else if (REG_WDATA_I[BIT_SRST]) begin
        new_rate = CFG_RESET[15:13];
        new_shut = CFG_RESET[BIT_SHUT];
        d.sty1 = CFG_RESET[BIT_STY1];
        d.polar1 = CFG_RESET[BIT_POLAR1];
        d.sty2 = CFG_RESET[BIT_STY2];
        d.polar2 = CFG_RESET[BIT_POLAR2];
      end else begin
        new_rate = REG_WDATA_I[15:13];
        new_shut = REG_WDATA_I[BIT_SHUT];
        d.sty1 = REG_WDATA_I[BIT_STY1];
        d.polar1 = REG_WDATA_I[BIT_POLAR1];
        d.sty2 = REG_WDATA_I[BIT_STY2];
        d.polar2 = REG_WDATA_I[BIT_POLAR2];
      end
      d.rate = new_rate;
      d.shut_sel = new_shut;
      d.abort = (q.st == ST_CONV) && !CONV_DONE_I;
      d.single = 1'b0;
      if (new_shut) begin
        if (REG_WDATA_I[BIT_SINGLE] && !q.unlock &&
            !REG_WDATA_I[BIT_SRST]) begin
          d.st = ST_CONV;
          d.single = 1'b1;
          d.start = 1'b1;
        end else begin
          d.st = ST_SHUT;
        end
      end else begin
        d.st = ST_CONV;
        d.start = 1'b1;
        d.per_cnt = period_of(new_rate);
      end
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        TEMP_ADDR: d.rdata = {q.temp, q.busy_cnt != 0, q.unlock};
        CFG_ADDR: d.rdata = {q.rate, 1'b0, q.shut_sel, upper[0], lower[0],
                             q.sty1, q.polar1, upper[1], lower[1], q.sty2,
                             q.polar2, 3'b000};
        default: d.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      q <= MAIN_RESET;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Limit channels
  // ***************************************************************
  assign hi_lim[0] = HIGH_LIMIT1_I;
  assign lo_lim[0] = LOW_LIMIT1_I;
  assign hi_lim[1] = HIGH_LIMIT2_I;
  assign lo_lim[1] = LOW_LIMIT2_I;
  assign sty = {q.sty2, q.sty1};
  assign pol = {q.polar2, q.polar1};

  for (genvar c = 0; c < 2; c++) begin : g_chan
    limit_channel u_chan (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .done_i(done),
      .result_i(TEMP_RESULT_I),
      .high_i(hi_lim[c]),
      .low_i(lo_lim[c]),
      .style_i(sty[c]),
      .pol_i(pol[c]),
      .rd_clr_i(cfg_rd),
      .upper_o(upper[c]),
      .lower_o(lower[c]),
      .alarm_o(alarm[c])
    );
  end

  assign REG_RDATA_O = q.rdata;
  assign CONV_START_O = q.start;
  assign CONV_ABORT_O = q.abort;
  assign SHUTDOWN_O = (q.st == ST_SHUT);
  assign NV_PROG_O = q.prog;
  assign NV_DATA_O = q.nv_data;
  assign ALARM_OUTPUT_1_O = alarm[0];
  assign ALARM_OUTPUT_2_O = alarm[1];

endmodule // temp_sensor_config_alert

// ### core/sensor_cfg_pkg.sv
// Constants and types shared by the configuration and alarm logic
// How it works
// - Unlock clear: config writes land in live register; set: they program nonvolatile copy.
// - Any config write aborts the running conversion; a locked write then obeys the new bits.
// - A write selecting shutdown stops at once, no finishing of conversion.
// - A rate change discards the conversion and restarts timed by new rate.
// - Sixteen-bit config register at pointer 1h, resets to A000h.
// - Rate field bits 15-13, reset 5h, paces continuous mode only.
// - Trigger bit 12 in shutdown runs one conversion, then back to shutdown.
// - Trigger bit always reads zero.
// - Bit 11: 0 continuous, 1 shutdown with conversions only on trigger.
// - Bit 10 flags result above channel-1 high limit.
// - Bit 9 flags result below channel-1 low limit in window mode; else 0.
// - Style 0: flags set on leaving window, cleared by config read.
// - Style 1: upper flag sets above high, clears only below low.
// - Style 1: flags change only at conversion end; reads do not clear.
// - Bit 7 polarity: alarm 1 active low at 0, high at 1.
// - Channel 2 compares against its own limits with low-byte controls.
// - Unlock bit in temperature register: 1 unlocks, 0 locks.
package sensor_cfg_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [3:0] TEMP_ADDR = 4'h0;
  localparam logic [3:0] CFG_ADDR = 4'h1;
  localparam logic [15:0] CFG_RESET = 16'ha000;
  localparam logic [2:0] RATE_RESET = 3'h5;
  localparam logic UNLOCK_RESET = 1'b0;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int RATE_LSB = 13;
  localparam int BIT_SINGLE = 12;
  localparam int BIT_SHUT = 11;
  localparam int BIT_STY1 = 8;
  localparam int BIT_POLAR1 = 7;
  localparam int BIT_STY2 = 4;
  localparam int BIT_POLAR2 = 3;
  localparam int BIT_SRST = 1;
  localparam int BIT_UNLOCK = 0;
  // Stored bits: rate, shutdown select, styles and polarities
  localparam logic [15:0] CFG_WR_MASK = 16'he998;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_MS = 16;
  localparam int unsigned PROG_CYCLES = PROG_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned RATE_UNIT_US = 15625;
  localparam int unsigned RATE_UNIT_CYCLES = RATE_UNIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_SHUT = 3'b001,
    ST_CONV = 3'b010,
    ST_WAIT = 3'b100
  } conv_state_t;

endpackage

// ### core/limit_channel.sv
// One limit comparator channel with flags and alarm pin drive
`timescale 1ns/1ns
module limit_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic done_i,
  input wire logic signed [13:0] result_i,
  input wire logic signed [13:0] high_i,
  input wire logic signed [13:0] low_i,
  input wire logic style_i,
  input wire logic pol_i,
  input wire logic rd_clr_i,
  output logic upper_o,
  output logic lower_o,
  output logic alarm_o
);

  typedef struct packed {
    logic upper;
    logic lower;
    logic alarm;
  } chan_t;

  chan_t q;
  chan_t d;

  always_comb begin
    d = q;
    if (!style_i) begin
      // Sticky window flags, a new excursion beats the read clear
      d.upper = (done_i && result_i > high_i) || (q.upper && !rd_clr_i);
      d.lower = (done_i && result_i < low_i) || (q.lower && !rd_clr_i);
    end else begin
      d.lower = 1'b0;
      if (done_i) begin
        if (result_i > high_i) begin
          d.upper = 1'b1;
        end else if (result_i < low_i) begin
          d.upper = 1'b0;
        end
      end
    end
    d.alarm = pol_i ? (d.upper | d.lower) : !(d.upper | d.lower);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{upper: 1'b0, lower: 1'b0, alarm: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign upper_o = q.upper;
  assign lower_o = q.lower;
  assign alarm_o = q.alarm;

endmodule // limit_channel

// ### dv/conv_model.sv
// Behavioural converter answering conversion start and abort
`timescale 1ns/1ns
module conv_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] delay_i,
  input wire logic signed [13:0] value_i,
  output logic done_o,
  output logic signed [13:0] result_o
);
  int cnt = 0;
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (start_i) begin
      cnt <= delay_i;
    end else if (abort_i) begin
      cnt <= 0;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // Result is only meaningful with the done pulse
  assign result_o = done_o ? value_i : ~value_i;
endmodule // conv_model

// ### dv/sensor_cfg_chk.sv
// Property checker for configuration and conversion control
`timescale 1ns/1ns
module sensor_cfg_chk #(
  parameter int unsigned PROG_WAIT = 20
) (
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic CONV_DONE_I,
  input wire logic CONV_START_O,
  input wire logic CONV_ABORT_O,
  input wire logic SHUTDOWN_O,
  input wire logic NV_PROG_O,
  input wire logic [15:0] NV_DATA_O
);
  import sensor_cfg_pkg::*;
  logic unlock_q, conv_q, wr_ok, cfg_wr;
  int unsigned busy_q;
  // Busy window tracks the design's refusal span cycle for cycle
  assign wr_ok = REG_WR_I && busy_q == 0;
  assign cfg_wr = wr_ok && REG_ADDR_I == CFG_ADDR && !unlock_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      unlock_q <= 1'b0;
      conv_q <= 1'b1;
      busy_q <= 0;
    end else begin
      if (wr_ok && REG_ADDR_I == TEMP_ADDR) unlock_q <= REG_WDATA_I[0];
      if (wr_ok && REG_ADDR_I == CFG_ADDR && unlock_q) busy_q <= PROG_WAIT;
      else if (busy_q != 0) busy_q <= busy_q - 1;
      conv_q <= CONV_START_O ||
        (conv_q && !CONV_DONE_I && !CONV_ABORT_O && !SHUTDOWN_O);
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_shut_wr;
    cfg_wr && REG_WDATA_I[12:11] == 2'h1 && !REG_WDATA_I[1];
  endsequence
  sequence s_one_shot;
    cfg_wr && REG_WDATA_I[12:11] == 2'h3 && !REG_WDATA_I[1] && SHUTDOWN_O;
  endsequence
  a_shut_write_stops: assert property (s_shut_wr |=> SHUTDOWN_O)
    else $error("shutdown write did not stop");
  a_one_shot_go: assert property (s_one_shot |=> CONV_START_O)
    else $error("one shot did not start");
  a_write_aborts: assert property (cfg_wr && conv_q && !CONV_DONE_I |=>
    CONV_ABORT_O) else $error("write did not abort");
  a_rate_restart: assert property (cfg_wr && !REG_WDATA_I[11] |->
    ##[1:2] CONV_START_O) else $error("no restart after write");
  a_nv_program: assert property (wr_ok && REG_ADDR_I == CFG_ADDR &&
    unlock_q |=> NV_PROG_O && NV_DATA_O == ($past(REG_WDATA_I) &
    CFG_WR_MASK)) else $error("nonvolatile program wrong");
  a_live_no_prog: assert property (cfg_wr |=> !NV_PROG_O)
    else $error("locked write programmed");
  a_cfg_zero_bits: assert property (REG_RD_I &&
    REG_ADDR_I == CFG_ADDR |=> REG_RDATA_O[12] == 1'b0 &&
    REG_RDATA_O[2:0] == 3'h0) else $error("config zero bits set");
  a_unmapped_zero: assert property (REG_RD_I && REG_ADDR_I > CFG_ADDR |=>
    REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
  a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved");
endmodule // sensor_cfg_chk

// ### dv/tb_top.sv
// Testbench for configuration register and alarm logic
`timescale 1ns/1ns
module tb_top;
  import sensor_cfg_pkg::*;
  localparam int unsigned PW = 20;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, nvdata;
  logic done, start, abort, shut, prog, al1, al2;
  logic signed [13:0] result, value = 14'sd0;
  logic signed [13:0] hi = 14'sd1000, lo = -14'sd1000;
  logic [7:0] delay = 8'h06;
  int error_cnt = 0, comparisons = 0;
  always #5 clk = ~clk;
  temp_sensor_config_alert #(.PROG_WAIT(PW), .RATE_UNIT(4)) dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .CONV_DONE_I(done), .TEMP_RESULT_I(result), .HIGH_LIMIT1_I(hi),
    .LOW_LIMIT1_I(lo), .HIGH_LIMIT2_I(hi), .LOW_LIMIT2_I(lo),
    .CONV_START_O(start), .CONV_ABORT_O(abort), .SHUTDOWN_O(shut),
    .NV_PROG_O(prog), .NV_DATA_O(nvdata), .ALARM_OUTPUT_1_O(al1),
    .ALARM_OUTPUT_2_O(al2));
  conv_model conv (.clk_i(clk), .start_i(start), .abort_i(abort),
    .delay_i(delay), .value_i(value), .done_o(done), .result_o(result));
  // ***************************************************************
  // Bus and compare tasks
  // ***************************************************************
  task chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task wr16(logic [3:0] a, logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    @(negedge clk);
  endtask
  task rd16(logic [3:0] a, logic [15:0] exp);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    @(posedge clk); @(negedge clk);
    chk("rdata", exp, rdata);
  endtask
  task wait_done;
    int n;
    n = 0;
    @(posedge clk);
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk); n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    @(posedge clk); @(posedge clk); @(negedge clk);
  endtask
  task report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_reset;
    rd16(CFG_ADDR, CFG_RESET);
    rd16(TEMP_ADDR, 16'h0000);
    rd16(4'h9, 16'h0000);
  endtask
  task t_one_shot;
    wr16(CFG_ADDR, 16'h0800);
    rd16(CFG_ADDR, 16'h0800);
    delay <= 8'd20; value <= 14'sh0123;
    wr16(CFG_ADDR, 16'h1800);
    wait_done();
    chk("shut", 16'h0001, {15'h0000, shut});
    rd16(CFG_ADDR, 16'h0800);
    rd16(TEMP_ADDR, {14'h0123, 2'b00});
  endtask
  task t_window;
    delay <= 8'd6; value <= 14'sd2000;
    wr16(CFG_ADDR, 16'he088);
    wait_done();
    chk("alarm", 16'h0003, {14'h0000, al2, al1});
    value <= 14'sd0;
    rd16(CFG_ADDR, 16'he4c8);
    wait_done();
    rd16(CFG_ADDR, 16'he088);
    value <= -14'sd2000;
    wait_done();
    rd16(CFG_ADDR, 16'he2a8);
  endtask
  task t_hyst;
    value <= 14'sd2000;
    wr16(CFG_ADDR, 16'he110);
    wait_done();
    chk("alarm", 16'h0000, {14'h0000, al2, al1});
    rd16(CFG_ADDR, 16'he550);
    rd16(CFG_ADDR, 16'he550);
    value <= 14'sd0;
    wait_done();
    rd16(CFG_ADDR, 16'he550);
    value <= -14'sd2000;
    wait_done();
    rd16(CFG_ADDR, 16'he110);
    chk("alarm", 16'h0003, {14'h0000, al2, al1});
  endtask
  task t_nonvol;
    wr16(TEMP_ADDR, 16'h0001);
    rd16(TEMP_ADDR, {value, 2'b01});
    wr16(CFG_ADDR, 16'h0800);
    chk("nvdata", 16'h0800, nvdata);
    chk("shut", 16'h0000, {15'h0000, shut});
    wr16(TEMP_ADDR, 16'h0000);
    rd16(TEMP_ADDR, {value, 2'b11});
    repeat (PW + 5) @(posedge clk);
    wr16(TEMP_ADDR, 16'h0000);
    rd16(TEMP_ADDR, {value, 2'b00});
    rd16(CFG_ADDR, 16'he110);
    wr16(CFG_ADDR, 16'h0002);
    rd16(CFG_ADDR, CFG_RESET);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_one_shot();
    t_window();
    t_hyst();
    t_nonvol();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // tb_top
bind temp_sensor_config_alert sensor_cfg_chk #(.PROG_WAIT(PROG_WAIT)) u_chk (.*);
